// file: cct_pkg.sv
/*
 * Constants and types for the 16-bit capture/compare timer.
 * Assumes a single 100 MHz bus clock and AHB-Lite register access.
 */
`default_nettype none

package cct_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Register byte offsets
   localparam logic [7:0] OFS_COUNT = 8'h00;
   localparam logic [7:0] OFS_CC0 = 8'h04;
   localparam logic [7:0] OFS_CC1 = 8'h08;
   localparam logic [7:0] OFS_CTLA = 8'h0c;
   localparam logic [7:0] OFS_CTLB = 8'h10;
   localparam logic [7:0] OFS_WAVE = 8'h14;
   localparam logic [7:0] OFS_PORT = 8'h18;

   ////////////////////////////////////////////////////////////////////////
   // control_reg_a fields
   localparam int CA_RUN = 0;
   localparam int CA_SRC = 1;
   localparam int CA_POL = 3;
   localparam int CA_IRQSEL = 5;
   localparam int CA_TRIG = 6;
   // Bits whose rewrite may post an ext interrupt request
   localparam logic [7:0] CA_CFG_MSK = 8'h78;

   // control_reg_b fields
   localparam int CB_FLT = 0;
   localparam int CB_CLR = 2;
   localparam int CB_MODE = 3;
   localparam int CB_LVL0 = 4;
   localparam int CB_LVL1 = 6;

   // waveform_out_ctrl_reg fields
   localparam int WV_EN = 0;
   localparam int WV_INV0 = 6;
   localparam int WV_INV1 = 7;

   ////////////////////////////////////////////////////////////////////////
   // Reset values and counts
   localparam logic [7:0] RST_CTL = 8'h00;
   localparam logic [15:0] RST_CNT = 16'h0000;
   localparam logic [15:0] CNT_MAX = 16'hffff;
   localparam int DIV8 = 8;
   localparam int DIV32 = 32;
   localparam int FLT_SAMPLES = 3;
   localparam int PINS = 6;
   localparam int PINS_INV0 = 3;
   localparam logic FIXED_LVL = 1'b0;

   ////////////////////////////////////////////////////////////////////////
   // Types
   typedef enum logic [1:0] {
      LVL_KEEP = 2'b00,
      LVL_LOW = 2'b01,
      LVL_HIGH = 2'b10,
      LVL_TOG = 2'b11
   } cct_lvl_t;

   typedef struct packed {
      logic ext;
      logic cmp0;
      logic cmp1;
      logic ovf;
   } cct_irq_t;

   typedef struct packed {
      logic [5:0] level;
      logic [5:0] sel;
   } cct_pins_t;

endpackage

`default_nettype wire

// file: cct_timer.sv
/*
 * 16-bit capture/compare timer with AHB-Lite register slave.
 * Assumes hclk at 100 MHz; pins and oscillator clocks are asynchronous
 * and are synchronised here; the port direction logic lies outside.
 */
// Decided for this implementation: the register addresses and register access over AHB-Lite.
`default_nettype none

// Behaviour
// [R01] One 16-bit counter, input capture or output compare mode.
// [R02] Count source: clock, clock/8, clock/32 or fast oscillator.
// [R03] Run bit set starts counting, cleared halts it.
// [R04] Counter forced to zero while stopped, both modes.
// [R05] Capture mode: active edge copies counter into capture register.
// [R06] Trigger select picks capture pin or slow oscillator /128.
// [R07] Two-bit polarity picks rising, falling or both edges.
// [R08] Capture input digitally filtered, sample rate by two-bit field.
// [R09] Capture interrupt on active edge, after filter delay.
// [R10] Overflow interrupt in both modes.
// [R11] Capture mode ignores writes to counter and capture register.
// [R12] Compare mode: separate interrupts on compare 0 and 1 match.
// [R13] Compare load: at once stopped, overflow free-run, match1 clear mode.
// [R14] Reload bit: clear on compare 1 match or free-run.
// [R15] Two-bit fields give pin level on compare 0 and 1 matches.
// [R16] Six pin enables gate the waveform onto each pin.
// [R17] Two invert bits invert the waveform before the pins.
// [R18] Enabled pin: waveform if port bit 1, fixed level if 0.
// [R19] Compare mode: pin edge interrupts regardless of select bit.
// [R20] Counter and compare values read as one coherent word.
// [R21] Software changes restricted bits only while stopped; the code takes control register writes while running.
// [R22] Rewriting polarity, select or trigger bits may post a request.
// [R23] Counter wraps from maximum to zero and keeps counting.
module cct_timer (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic capture_input_pin,
   input wire logic slow_osc_div128_clk,
   input wire logic fast_osc_clk,
   output cct_pkg::cct_irq_t irq_o,
   output cct_pkg::cct_pins_t pins_o
);
   import cct_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Helpers
   function automatic logic src_tick(input logic [1:0] sel,
                                     input logic [4:0] pre,
                                     input logic fast);
      case (sel)
         2'd0: src_tick = 1'b1;
         2'd1: src_tick = (pre[2:0] == 3'(DIV8 - 1));
         2'd2: src_tick = (pre == 5'(DIV32 - 1));
         default: src_tick = fast;
      endcase
   endfunction

   function automatic logic apply_lvl(input logic [1:0] lvl,
                                      input logic cur);
      case (lvl)
         LVL_LOW: apply_lvl = 1'b0;
         LVL_HIGH: apply_lvl = 1'b1;
         LVL_TOG: apply_lvl = ~cur;
         default: apply_lvl = cur;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Declarations
   logic [2:0] sync1_r, sync2_r;
   logic fast_d_r, fast_tick;
   logic [4:0] pre_r;
   logic wr_r;
   logic [7:0] adr_r;
   logic [7:0] ca_r, cb_r, wv_r;
   logic [5:0] port_r;
   logic [15:0] cnt_r, cmp0_r, cmp1_r, buf0_r, buf1_r;
   logic flt_r, flt_d_r;
   logic [1:0] agree_r;
   logic wave_r;
   logic run, mode_cmp, clr_en, cnt_tick, samp, trig;
   logic m0, m1, clr_hit, ovf, load, edge_ev, cap_ev, cfg_chg;
   logic wr_ca, wr_cb, wr_wv, wr_pt, wr_c0, wr_c1, ap;

   assign run = ca_r[CA_RUN];
   assign mode_cmp = cb_r[CB_MODE];
   assign clr_en = cb_r[CB_CLR];

   ////////////////////////////////////////////////////////////////////////
   // Pin and oscillator synchronisers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync1_r <= 3'h0;
         sync2_r <= 3'h0;
         fast_d_r <= 1'b0;
      end else begin
         sync1_r <= {fast_osc_clk, slow_osc_div128_clk, capture_input_pin};
         sync2_r <= sync1_r;
         fast_d_r <= sync2_r[2];
      end
   end
   assign fast_tick = sync2_r[2] & ~fast_d_r;

   // Free-running prescaler for the divided sources
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pre_r <= 5'h00;
      end else begin
         pre_r <= pre_r + 5'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // AHB-Lite slave: zero wait states, always OKAY
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign ap = hsel & hready & htrans[1];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_r <= 1'b0;
         adr_r <= 8'h00;
      end else begin
         wr_r <= ap & hwrite;
         adr_r <= haddr[7:0];
      end
   end

   // Whole-word read sampled in one edge keeps 16-bit values coherent
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0;
      end else if (ap && !hwrite) begin
         case (haddr[7:0])
            OFS_COUNT: hrdata <= {16'h0, cnt_r}; // [R20]
            OFS_CC0: hrdata <= {16'h0, cmp0_r}; // [R20]
            OFS_CC1: hrdata <= {16'h0, cmp1_r};
            OFS_CTLA: hrdata <= {24'h0, ca_r};
            OFS_CTLB: hrdata <= {24'h0, cb_r};
            OFS_WAVE: hrdata <= {24'h0, wv_r};
            OFS_PORT: hrdata <= {26'h0, port_r};
            default: hrdata <= 32'h0;
         endcase
      end
   end

   assign wr_ca = wr_r && (adr_r == OFS_CTLA);
   assign wr_cb = wr_r && (adr_r == OFS_CTLB);
   assign wr_wv = wr_r && (adr_r == OFS_WAVE);
   assign wr_pt = wr_r && (adr_r == OFS_PORT);
   assign wr_c0 = wr_r && (adr_r == OFS_CC0);
   assign wr_c1 = wr_r && (adr_r == OFS_CC1);

   // Control registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ca_r <= RST_CTL;
         cb_r <= RST_CTL;
         wv_r <= RST_CTL;
         port_r <= 6'h00;
      end else begin
         if (wr_ca) begin
            ca_r <= hwdata[7:0]; // [R03]
         end
         if (wr_cb) begin
            cb_r <= hwdata[7:0];
         end
         if (wr_wv) begin
            wv_r <= hwdata[7:0];
         end
         if (wr_pt) begin
            port_r <= hwdata[5:0];
         end
      end
   end

   // A write that changes edge, select or trigger bits posts a request
   assign cfg_chg = wr_ca &&
                    (((hwdata[7:0] ^ ca_r) & CA_CFG_MSK) != 8'h00); // [R22]

   ////////////////////////////////////////////////////////////////////////
   // Capture trigger path
   assign trig = (ca_r[CA_TRIG] && !mode_cmp) ? sync2_r[1]
                                              : sync2_r[0]; // [R06]
   assign samp = src_tick(cb_r[CB_FLT +: 2] - 2'd1, pre_r, 1'b0); // [R08]

   // Filter field 0 passes trig straight through; otherwise level changes only after FLT_SAMPLES differing samples
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         flt_r <= 1'b0;
         agree_r <= 2'h0;
      end else if (cb_r[CB_FLT +: 2] == 2'd0) begin
         flt_r <= trig;
         agree_r <= 2'h0;
      end else if (samp) begin
         if (trig == flt_r) begin
            agree_r <= 2'h0;
         end else if (agree_r == 2'(FLT_SAMPLES - 1)) begin
            flt_r <= trig; // [R08]
            agree_r <= 2'h0;
         end else begin
            agree_r <= agree_r + 2'h1;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         flt_d_r <= 1'b0;
      end else begin
         flt_d_r <= flt_r;
      end
   end

   // 00 rising, 01 falling, 1x both
   always_comb begin
      case (ca_r[CA_POL +: 2])
         2'b00: edge_ev = flt_r & ~flt_d_r; // [R07]
         2'b01: edge_ev = ~flt_r & flt_d_r; // [R07]
         default: edge_ev = flt_r ^ flt_d_r;
      endcase
   end
   assign cap_ev = edge_ev & ~mode_cmp;

   ////////////////////////////////////////////////////////////////////////
   // Counter
   assign cnt_tick = run & src_tick(ca_r[CA_SRC +: 2], pre_r,
                                    fast_tick); // [R02]
   assign m0 = mode_cmp & cnt_tick & (cnt_r == cmp0_r);
   assign m1 = mode_cmp & cnt_tick & (cnt_r == cmp1_r);
   assign clr_hit = m1 & clr_en; // [R14]
   assign ovf = cnt_tick & (cnt_r == CNT_MAX) & ~clr_hit;
   assign load = run & (clr_en ? m1 : ovf); // [R13]

   // Software writes to the count never land
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_r <= RST_CNT;
      end else if (!run) begin
         cnt_r <= RST_CNT; // [R04]
      end else if (clr_hit) begin
         cnt_r <= RST_CNT; // [R14]
      end else if (cnt_tick) begin
         cnt_r <= cnt_r + 16'h0001; // [R01] [R23]
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Capture / compare registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         buf0_r <= RST_CNT;
         buf1_r <= RST_CNT;
      end else begin
         if (wr_c0 && mode_cmp) begin // [R11]
            buf0_r <= hwdata[15:0];
         end
         if (wr_c1 && mode_cmp) begin
            buf1_r <= hwdata[15:0];
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cmp0_r <= RST_CNT;
      end else if (cap_ev) begin
         cmp0_r <= cnt_r; // [R05]
      end else if (mode_cmp) begin
         if (wr_c0 && !run) begin
            cmp0_r <= hwdata[15:0]; // [R13]
         end else if (load) begin
            cmp0_r <= buf0_r; // [R13]
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cmp1_r <= RST_CNT;
      end else if (mode_cmp) begin
         if (wr_c1 && !run) begin
            cmp1_r <= hwdata[15:0]; // [R13]
         end else if (load) begin
            cmp1_r <= buf1_r; // [R13]
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Interrupt request pulses
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_o <= '0;
      end else begin
         irq_o.ext <= (edge_ev & (mode_cmp | ~ca_r[CA_IRQSEL])) |
                      cfg_chg; // [R09] [R19] [R22]
         irq_o.cmp0 <= m0; // [R12]
         irq_o.cmp1 <= m1; // [R12]
         irq_o.ovf <= ovf; // [R10]
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Waveform generation and pin output
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wave_r <= 1'b0;
      end else if (!mode_cmp) begin
         wave_r <= 1'b0;
      end else if (m0 || m1) begin
         wave_r <= apply_lvl(m1 ? cb_r[CB_LVL1 +: 2] : 2'b00,
                   apply_lvl(m0 ? cb_r[CB_LVL0 +: 2] : 2'b00,
                             wave_r)); // [R15]
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pins_o <= '0;
      end else begin
         for (int i = 0; i < PINS; i++) begin
            pins_o.sel[i] <= mode_cmp & wv_r[WV_EN + i]; // [R16]
            if (!(mode_cmp && wv_r[WV_EN + i])) begin
               pins_o.level[i] <= FIXED_LVL; // [R16]
            end else if (port_r[i]) begin
               pins_o.level[i] <= wave_r ^
                  (i < PINS_INV0 ? wv_r[WV_INV0] : wv_r[WV_INV1]); // [R17]
            end else begin
               pins_o.level[i] <= FIXED_LVL; // [R18]
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Assertions
   stop_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
      !run |=> cnt_r == 16'h0000) // [R04]
      else $error("counter not zero while stopped");

   count_inc_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (cnt_tick && !clr_hit) |=> cnt_r == $past(cnt_r) + 16'h0001) // [R02]
      else $error("counter did not advance on tick");

   wrap_ovf_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (run && cnt_tick && cnt_r == 16'hffff && !clr_hit)
      |=> (cnt_r == 16'h0000) && irq_o.ovf) // [R23]
      else $error("wrap or overflow request missing");

   capture_val_a: assert property (@(posedge hclk) disable iff (!hresetn)
      cap_ev |=> cmp0_r == $past(cnt_r)) // [R05]
      else $error("capture register not loaded");

   capture_ro_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (!mode_cmp && !cap_ev && wr_c0 && !wr_cb) |=> $stable(cmp0_r)) // [R11]
      else $error("capture register took a write");

   cmp_irq_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (mode_cmp && cnt_tick && cnt_r == cmp0_r) |=> irq_o.cmp0) // [R12]
      else $error("compare 0 request missing");

   clr_match_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (run && mode_cmp && clr_en && cnt_tick && cnt_r == cmp1_r)
      |=> cnt_r == 16'h0000) // [R14]
      else $error("counter not cleared on compare 1");

   imm_load_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (mode_cmp && !run && wr_c1 && !wr_cb)
      |=> cmp1_r == $past(hwdata[15:0])) // [R13]
      else $error("stopped compare write not immediate");

   pin_fixed_a: assert property (@(posedge hclk) disable iff (!hresetn)
      !port_r[0] |=> !pins_o.level[0]) // [R18]
      else $error("pin 0 not at fixed level");

   ext_cmp_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (mode_cmp && edge_ev) |=> irq_o.ext) // [R19]
      else $error("pin edge request missing in compare mode");

endmodule

`default_nettype wire

// file: cct_far.sv
/*
 * Far-side model: capture pin source and oscillator levels.
 * Assumes hclk from the bench; every output changes after its edge.
 */
`default_nettype none

module cct_far (
   input wire logic hclk,
   output logic cap_pin,
   output logic slow_clk,
   output logic fast_clk
);
   timeunit 1ns;
   timeprecision 1ps;
   logic fast_on = 1'b0;
   logic phase = 1'b0;

   initial begin
      cap_pin = 1'b0;
      slow_clk = 1'b0;
      fast_clk = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////
   // Fast oscillator, four bus cycles a period while on
   always @(posedge hclk) begin
      phase <= ~phase;
      if (fast_on && phase) begin
         fast_clk <= ~fast_clk;
      end
   end

   // Drives capture pin (0) or slow oscillator (1), then holds it
   task automatic drive(input int which, input logic lvl, input int hold);
      @(posedge hclk);
      if (which == 0) begin
         cap_pin <= lvl;
      end else begin
         slow_clk <= lvl;
      end
      repeat (hold) @(posedge hclk);
   endtask
endmodule

`default_nettype wire

// file: capture_compare_timer16_bench.sv
/*
 * Self-checking bench for the capture/compare timer.
 * Assumes cct_pkg, cct_timer and cct_far are compiled before it.
 */
`default_nettype none

module capture_compare_timer16_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import cct_pkg::*;
   logic hclk;
   logic hresetn;
   logic [31:0] haddr;
   logic [1:0] htrans;
   logic hwrite;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   logic cap_pin;
   logic slow_clk;
   logic fast_clk;
   cct_irq_t irq;
   cct_pins_t pins;
   logic [31:0] v;
   logic [31:0] w;
   int n_errors = 0;
   int n_compared = 0;
   int n_ext = 0;
   int n_c0 = 0;
   int n_c1 = 0;
   int n_ovf = 0;
   int n_hi = 0;
   int n_bad = 0;
   int e;
   int e0;
   int e1;
   int eh;
   int eb;

   cct_timer DUT (
      .hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .capture_input_pin(cap_pin),
      .slow_osc_div128_clk(slow_clk), .fast_osc_clk(fast_clk),
      .irq_o(irq), .pins_o(pins)
   );

   cct_far u_far (
      .hclk(hclk), .cap_pin(cap_pin), .slow_clk(slow_clk),
      .fast_clk(fast_clk)
   );

   always #5 hclk = ~hclk;

   // Pulse and level counters; scenarios compare deltas
   always @(posedge hclk) begin
      n_ext <= n_ext + int'(irq.ext === 1'b1);
      n_c0 <= n_c0 + int'(irq.cmp0 === 1'b1);
      n_c1 <= n_c1 + int'(irq.cmp1 === 1'b1);
      n_ovf <= n_ovf + int'(irq.ovf === 1'b1);
      n_hi <= n_hi + int'(pins.level[0] === 1'b1);
      n_bad <= n_bad + int'(pins.level[3] === pins.level[0]);
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic conclude;
      $display("Compared %0d, errors %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic rdy;
      int i;
      i = 0;
      do begin
         @(posedge hclk);
         i++;
      end while (hreadyout !== 1'b1 && i < 50);
      if (i >= 50) begin
         n_errors++;
         conclude();
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      htrans <= 2'b10;
      haddr <= {24'h0, a};
      hwrite <= 1'b1;
      rdy();
      htrans <= 2'b00;
      hwdata <= d;
      rdy();
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge hclk);
      htrans <= 2'b10;
      haddr <= {24'h0, a};
      hwrite <= 1'b0;
      rdy();
      htrans <= 2'b00;
      rdy();
      d = hrdata;
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] d;
      rd(a, d);
      check("reg", d, exp);
   endtask

   task automatic cfg(input logic [7:0] a, input logic [31:0] d);
      wr(a, d);
      repeat (4) @(posedge hclk);
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      static int lo[4] = '{4, 10, 5, 19};
      static int hi[4] = '{4, 10, 5, 21};
      static int kk[4] = '{1, 77, 157, 77};
      hclk = 1'b0;
      hresetn = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hwdata = 32'h0;
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      for (int a = 0; a < 32; a += 4) begin
         rdchk(8'(a), 32'h0);
      end
      check("resp", 32'(hresp), 32'h0);
      for (int s = 0; s < 4; s++) begin
         u_far.fast_on <= (s == 3);
         cfg(OFS_CTLA, 32'(s << 1));
         wr(OFS_CTLA, 32'((s << 1) | 1));
         rd(OFS_COUNT, v);
         repeat (kk[s]) @(posedge hclk);
         rd(OFS_COUNT, w);
         check("tick", 32'(w - v >= lo[s] && w - v <= hi[s]), 1);
         wr(OFS_CTLA, 32'(s << 1));
         rdchk(OFS_COUNT, 32'h0);
      end
      cfg(OFS_CTLB, 32'h0);
      for (int p = 0; p < 3; p++) begin
         cfg(OFS_CTLA, 32'(p << 3));
         cfg(OFS_CTLA, 32'((p << 3) | 1));
         e = n_ext;
         u_far.drive(0, 1'b1, 20);
         u_far.drive(0, 1'b0, 20);
         check("ext", 32'(n_ext - e), (p == 2) ? 2 : 1);
         rd(OFS_CC0, v);
         rd(OFS_COUNT, w);
         check("cap", 32'(v != 0 && v < w), 1);
      end
      wr(OFS_CC0, 32'h1234);
      rdchk(OFS_CC0, v);
      wr(OFS_COUNT, 32'h5555);
      rd(OFS_COUNT, w);
      check("cnt_ro", 32'(w < 32'h5555), 1);
      // Stop before reconfiguring
      cfg(OFS_CTLA, 32'h0);
      cfg(OFS_CTLB, 32'h1);
      cfg(OFS_CTLA, 32'h1);
      e = n_ext;
      u_far.drive(0, 1'b1, 0);
      u_far.drive(0, 1'b0, 20);
      check("glitch", 32'(n_ext - e), 0);
      u_far.drive(0, 1'b1, 20);
      u_far.drive(0, 1'b0, 20);
      check("filt", 32'(n_ext - e), 1);
      cfg(OFS_CTLA, 32'h0);
      e = n_ext;
      cfg(OFS_CTLA, 32'h08);
      check("spur", 32'(n_ext - e), 1);
      cfg(OFS_CTLA, 32'h40);
      cfg(OFS_CTLA, 32'h41);
      e = n_ext;
      u_far.drive(1, 1'b1, 20);
      u_far.drive(1, 1'b0, 20);
      check("slow", 32'(n_ext - e), 1);
      cfg(OFS_CTLA, 32'h20);
      cfg(OFS_CTLB, 32'h6c);
      wr(OFS_WAVE, 32'hbf);
      wr(OFS_PORT, 32'h3f);
      wr(OFS_CC0, 32'h4);
      wr(OFS_CC1, 32'h9);
      rdchk(OFS_CC1, 32'h9);
      cfg(OFS_CTLA, 32'h21);
      repeat (20) @(posedge hclk);
      e0 = n_c0;
      e1 = n_c1;
      eh = n_hi;
      eb = n_bad;
      repeat (100) @(posedge hclk);
      check("cmp0", 32'(n_c0 - e0), 10);
      check("cmp1", 32'(n_c1 - e1), 10);
      check("wave", 32'(n_hi - eh), 50);
      check("inv", 32'(n_bad - eb), 0);
      rd(OFS_COUNT, v);
      check("clr", 32'(v < 10), 1);
      e = n_ext;
      u_far.drive(0, 1'b1, 20);
      u_far.drive(0, 1'b0, 20);
      check("pin", 32'(n_ext - e), 1);
      cfg(OFS_PORT, 32'h0f);
      w = 32'h0;
      repeat (10) begin
         @(posedge hclk);
         w = w | 32'(pins.level[5:4]);
      end
      check("fixed", w, 0);
      check("sel", 32'(pins.sel), 32'h3f);
      cfg(OFS_WAVE, 32'h0);
      check("off", 32'(pins.sel), 0);
      // Toggle on compare 0, keep on compare 1
      cfg(OFS_CTLA, 32'h20);
      cfg(OFS_CTLB, 32'h3c);
      cfg(OFS_WAVE, 32'h3f);
      wr(OFS_CC0, 32'h2);
      cfg(OFS_CTLA, 32'h21);
      repeat (20) @(posedge hclk);
      eh = n_hi;
      repeat (100) @(posedge hclk);
      check("toggle", 32'(n_hi - eh), 50);
      cfg(OFS_CTLA, 32'h20);
      cfg(OFS_CTLB, 32'h08);
      wr(OFS_CC0, 32'h10);
      cfg(OFS_CTLA, 32'h21);
      wr(OFS_CC0, 32'h20);
      rdchk(OFS_CC0, 32'h10);
      e = n_ovf;
      for (int i = 0; i < 70000 && n_ovf == e; i++) begin
         @(posedge hclk);
      end
      repeat (2) @(posedge hclk);
      check("ovf", 32'(n_ovf - e), 1);
      rdchk(OFS_CC0, 32'h20);
      rd(OFS_COUNT, v);
      check("wrap", 32'(v > 0 && v < 32'h40), 1);
      conclude();
   end
endmodule

`default_nettype wire
